// File: jcu_pkg.sv
// Purpose: shared constants for the character bridge between bus and link
// Assumes: 32-bit bus data, word-aligned registers
// Notes:   register byte address is four times the register index
package jcu_pkg;

    localparam int unsigned LVL_W = 16;

    // register indices; byte address is index times four
    localparam logic [1:0] DATA_IDX = 2'h0;
    localparam logic [1:0] CTRL_IDX = 2'h1;

    // data register fields
    localparam int unsigned DATA_LSB   = 0;
    localparam int unsigned RVALID_BIT = 15;
    localparam int unsigned RAVAIL_LSB = 16;

    // control register fields
    localparam int unsigned RE_BIT     = 0;
    localparam int unsigned WE_BIT     = 1;
    localparam int unsigned RI_BIT     = 8;
    localparam int unsigned WI_BIT     = 9;
    localparam int unsigned AC_BIT     = 10;
    localparam int unsigned WSPACE_LSB = 16;

    // values after reset
    localparam logic [1:0]  MASK_RST   = 2'h0;
    localparam logic [1:0]  STAT_RST   = 2'h0;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

    // build-time defaults
    localparam int unsigned DEPTH_DEF  = 64;
    localparam int unsigned THRESH_DEF = 8;

    typedef enum logic [1:0] {
        JCU_IDLE   = 2'b01,
        JCU_ANSWER = 2'b10
    } jcu_apb_state_type;

    function automatic logic [11:0] jcu_byte_addr(input logic [1:0] idx);
        jcu_byte_addr = {8'h00, idx, 2'b00};
    endfunction

endpackage

// File: jcu_fifo_if.sv
// Purpose: signals between the byte fifo and its user
// Assumes: single clock, valid/ready handshake on both sides
// Notes:   level counts stored bytes
`timescale 1ns/10ps
interface jcu_fifo_if;
    import jcu_pkg::*;

    logic             push_valid;
    logic             push_ready;
    logic [7:0]       push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [7:0]       pop_data;
    logic [LVL_W-1:0] level;

    modport fifo (
        input  push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data, level
    );
    modport user (
        output push_valid, push_data, pop_ready,
        input  push_ready, pop_valid, pop_data, level
    );
endinterface

// File: jcu_fifo.sv
// Purpose: byte fifo, power-of-two depth, register or memory-block style
// Assumes: depth between 8 and 32768
// Notes:   both styles show the head byte with the same timing
`timescale 1ns/10ps
module jcu_fifo
    import jcu_pkg::*;
#(
    parameter int unsigned DEPTH    = DEPTH_DEF,
    parameter bit          USE_REGS = 1'b0
)(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic srst_in,
    // fifo ports
    jcu_fifo_if.fifo  port
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [7:0]       mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [LVL_W-1:0] count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [LVL_W-1:0] next_count;
    logic             do_push;
    logic             do_pop;

    assign port.push_ready = (count != LVL_W'(DEPTH));
    assign port.pop_valid  = (count != '0);
    assign port.level      = count;
    assign do_push = port.push_valid && port.push_ready;
    assign do_pop  = port.pop_ready && port.pop_valid;

    always_comb
    begin
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count;
        if (do_push && !do_pop)
            next_count = count + 1'b1;
        else if (do_pop && !do_push)
            next_count = count - 1'b1;
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
        if (do_push)
            mem[wr_ptr] <= port.push_data;
    end

    generate
        if (USE_REGS)
        begin : g_regs
            // logic-element style: head read straight from the array
            assign port.pop_data = mem[rd_ptr];
        end
        else
        begin : g_block
            // block style: registered read port looks one entry ahead,
            // with bypass so a byte written into an empty slot shows at once
            logic [7:0] head;
            always_ff @(posedge clk_in)
            begin
                if (do_push && next_rd_ptr == wr_ptr)
                    head <= port.push_data;
                else
                    head <= mem[next_rd_ptr];
            end
            assign port.pop_data = head;
        end
    endgenerate
endmodule

// File: jcu_top.sv
// Purpose: character bridge between a register bus and a link hub node
// Assumes: apb slave on clk_in, link side synchronous to the same clock
// Notes:   one interrupt output; sticky flags cleared by reading control
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module jcu_top
    import jcu_pkg::*;
#(
    parameter int unsigned WR_DEPTH    = DEPTH_DEF,
    parameter int unsigned RD_DEPTH    = DEPTH_DEF,
    parameter int unsigned WR_THRESH   = THRESH_DEF,
    parameter int unsigned RD_THRESH   = THRESH_DEF,
    parameter bit          WR_USE_REGS = 1'b0,
    parameter bit          RD_USE_REGS = 1'b0
)(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic [31:0]      prdata_out,
    output logic             pslverr_out,
    // interrupt
    output logic             irq_out,
    // hub node: select plus byte streams
    input  wire logic        node_sel_in,
    output logic             tx_valid_out,
    output logic [7:0]       tx_data_out,
    input  wire logic        tx_ready_in,
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_data_in,
    output logic             rx_ready_out
);
    // a threshold at or above the depth could never be crossed
    initial
    begin
        assert (WR_DEPTH >= 8 && WR_DEPTH <= 32768 && (WR_DEPTH & (WR_DEPTH - 1)) == 0);
        assert (RD_DEPTH >= 8 && RD_DEPTH <= 32768 && (RD_DEPTH & (RD_DEPTH - 1)) == 0);
        assert (WR_THRESH < WR_DEPTH);
        assert (RD_THRESH < RD_DEPTH);
    end

    jcu_fifo_if wr_if ();
    jcu_fifo_if rd_if ();

    jcu_fifo #(
        .DEPTH    (WR_DEPTH),
        .USE_REGS (WR_USE_REGS)
    ) u_wr_fifo (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .port    (wr_if.fifo)
    );

    jcu_fifo #(
        .DEPTH    (RD_DEPTH),
        .USE_REGS (RD_USE_REGS)
    ) u_rd_fifo (
        .clk_in  (clk_in),
        .srst_in (srst_in),
        .port    (rd_if.fifo)
    );

    // event levels are the fill counts just before each crossing
    localparam logic [LVL_W-1:0] WR_EVT_LVL = LVL_W'(WR_THRESH + 1);
    localparam logic [LVL_W-1:0] RD_EVT_LVL = LVL_W'(RD_DEPTH - RD_THRESH - 1);
    localparam logic [LVL_W-1:0] WR_DEPTH_L = LVL_W'(WR_DEPTH);
    localparam logic [LVL_W-1:0] RD_DEPTH_L = LVL_W'(RD_DEPTH);

    // data word: payload byte, valid flag and bytes left after the pop
    function automatic logic [31:0] data_word(
        input logic             valid,
        input logic [7:0]       head,
        input logic [LVL_W-1:0] left
    );
        data_word                      = PRDATA_RST;
        data_word[RVALID_BIT]          = valid;
        data_word[RAVAIL_LSB +: LVL_W] = left;
        // empty fifo reads as zero, never as a stale or unwritten byte
        if (valid)
            data_word[DATA_LSB +: 8]   = head;
    endfunction

    // control word: masks, sticky flags, link activity and free space
    function automatic logic [31:0] ctrl_word(
        input logic [1:0]       msk,
        input logic [1:0]       flg,
        input logic             act,
        input logic [LVL_W-1:0] room
    );
        ctrl_word                      = PRDATA_RST;
        ctrl_word[RE_BIT]              = msk[0];
        ctrl_word[WE_BIT]              = msk[1];
        ctrl_word[RI_BIT]              = flg[0];
        ctrl_word[WI_BIT]              = flg[1];
        ctrl_word[AC_BIT]              = act;
        ctrl_word[WSPACE_LSB +: LVL_W] = room;
    endfunction

    // bus state
    jcu_apb_state_type state;
    jcu_apb_state_type next_state;
    logic              next_pready;
    logic [31:0]       next_prdata;
    logic              next_pslverr;
    logic              pop_pend;
    logic              next_pop_pend;

    // control and status
    logic [1:0]        mask;
    logic [1:0]        next_mask;
    logic [1:0]        stat;
    logic [1:0]        next_stat;
    logic              active;
    logic              next_active;
    logic              next_irq;

    // link side
    logic              next_tx_valid;
    logic [7:0]        next_tx_data;
    logic              next_rx_ready;

    logic              setup_hit;
    logic              complete;
    logic              hit_data;
    logic              hit_ctrl;
    logic              tx_load;
    logic              tx_take;
    logic              rx_take;
    logic              wr_evt;
    logic              rd_evt;
    logic [LVL_W-1:0]  wspace;
    logic [LVL_W-1:0]  ravail;

    assign setup_hit = psel_in && penable_in && (state == JCU_IDLE);
    assign complete  = psel_in && penable_in && (state == JCU_ANSWER);
    assign hit_data  = (paddr_in == jcu_byte_addr(DATA_IDX));
    assign hit_ctrl  = (paddr_in == jcu_byte_addr(CTRL_IDX));
    // free and waiting counts as software sees them
    assign wspace    = WR_DEPTH_L - wr_if.level;
    assign ravail    = rd_if.pop_valid ? rd_if.level - 1'b1 : rd_if.level;

    // link transfers only move while the hub routes to this node
    assign tx_take = node_sel_in && tx_valid_out && tx_ready_in;
    assign rx_take = node_sel_in && rx_valid_in && rx_ready_out;
    assign tx_load = wr_if.pop_valid && (!tx_valid_out || tx_take);

    assign wr_if.push_valid = complete && pwrite_in && hit_data;
    assign wr_if.push_data  = pwdata_in[DATA_LSB +: 8];
    assign wr_if.pop_ready  = tx_load;
    assign rd_if.push_valid = rx_take;
    assign rd_if.push_data  = rx_data_in;
    assign rd_if.pop_ready  = complete && !pwrite_in && hit_data && pop_pend;

    // queued count drops to threshold as the link drains
    assign wr_evt = tx_load && (wr_if.level == WR_EVT_LVL);
    // free space drops to threshold as the link fills
    assign rd_evt = rx_take && (rd_if.level == RD_EVT_LVL);

    always_comb
    begin
        next_state    = state;
        next_pready   = 1'b0;
        next_prdata   = prdata_out;
        next_pslverr  = 1'b0;
        next_pop_pend = pop_pend;
        case (state)
            JCU_IDLE:
            begin
                if (setup_hit)
                begin
                    // read data is frozen here so a byte arriving during
                    // the answer cycle is never popped unseen
                    next_state    = JCU_ANSWER;
                    next_pready   = 1'b1;
                    next_prdata   = PRDATA_RST;
                    next_pop_pend = 1'b0;
                    next_pslverr  = !(hit_data || hit_ctrl);
                    if (!pwrite_in && hit_data)
                    begin
                        next_prdata   = data_word(rd_if.pop_valid, rd_if.pop_data, ravail);
                        next_pop_pend = rd_if.pop_valid;
                    end
                    else if (!pwrite_in && hit_ctrl)
                    begin
                        next_prdata = ctrl_word(mask, stat, active, wspace);
                    end
                end
            end
            JCU_ANSWER:
            begin
                next_state    = JCU_IDLE;
                next_pop_pend = 1'b0;
            end
            default:
            begin
                next_state = JCU_IDLE;
            end
        endcase
    end

    // masks, sticky flags and link activity
    always_comb
    begin
        next_mask   = mask;
        next_stat   = stat;
        next_active = active;
        if (complete && pwrite_in && hit_ctrl)
        begin
            next_mask = {pwdata_in[WE_BIT], pwdata_in[RE_BIT]};
            if (pwdata_in[AC_BIT])
                next_active = 1'b0;
        end
        // reading control acknowledges the sticky flags
        if (complete && !pwrite_in && hit_ctrl)
            next_stat = STAT_RST;
        // an event in the clearing cycle still lands
        if (rd_evt)
            next_stat[0] = 1'b1;
        if (wr_evt)
            next_stat[1] = 1'b1;
        if (tx_take || rx_take)
            next_active = 1'b1;
        next_irq = |(next_stat & next_mask);
    end

    always_comb
    begin
        next_tx_valid = tx_valid_out;
        next_tx_data  = tx_data_out;
        if (tx_load)
        begin
            next_tx_valid = 1'b1;
            next_tx_data  = wr_if.pop_data;
        end
        else if (tx_take)
        begin
            next_tx_valid = 1'b0;
        end
        // conservative: assumes no pop frees a slot this cycle
        next_rx_ready = (rd_if.level + LVL_W'(rx_take)) < RD_DEPTH_L;
    end

    // every output leaves straight from a flip-flop
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state        <= JCU_IDLE;
            pready_out   <= 1'b0;
            prdata_out   <= PRDATA_RST;
            pslverr_out  <= 1'b0;
            pop_pend     <= 1'b0;
            mask         <= MASK_RST;
            stat         <= STAT_RST;
            active       <= 1'b0;
            irq_out      <= 1'b0;
            tx_valid_out <= 1'b0;
            tx_data_out  <= 8'h00;
            rx_ready_out <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            pready_out   <= next_pready;
            prdata_out   <= next_prdata;
            pslverr_out  <= next_pslverr;
            pop_pend     <= next_pop_pend;
            mask         <= next_mask;
            stat         <= next_stat;
            active       <= next_active;
            irq_out      <= next_irq;
            tx_valid_out <= next_tx_valid;
            tx_data_out  <= next_tx_data;
            rx_ready_out <= next_rx_ready;
        end
    end
endmodule

// File: jcu_assertions.sv
// Purpose: bus and link timing checks for the character bridge
// Assumes: one clock, synchronous reset
// Notes:   bound into every jcu_top
`timescale 1ns/10ps
module jcu_assertions
    import jcu_pkg::*;
#(
    parameter int unsigned WR_DEPTH = DEPTH_DEF,
    parameter int unsigned RD_DEPTH = DEPTH_DEF
)(
    // clock and reset
    input wire logic        clk_in,
    input wire logic        srst_in,
    // apb
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out,
    input wire logic [31:0] prdata_out,
    input wire logic        pslverr_out,
    // interrupt and hub node
    input wire logic        irq_out,
    input wire logic        node_sel_in,
    input wire logic        tx_valid_out,
    input wire logic [7:0]  tx_data_out,
    input wire logic        tx_ready_in,
    input wire logic        rx_valid_in,
    input wire logic [7:0]  rx_data_in,
    input wire logic        rx_ready_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    sequence s_access;
        psel_in && penable_in && !pready_out;
    endsequence
    sequence s_rd_data;
        pready_out && !pwrite_in && paddr_in == 12'h000;
    endsequence
    sequence s_rd_ctrl;
        pready_out && !pwrite_in && paddr_in == 12'h004;
    endsequence

    AST_PREADY_WAIT: assert property (s_access |=> pready_out)
        else $error("no answer after access edge");
    AST_PREADY_ONE: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    AST_SLVERR: assert property (pready_out |-> pslverr_out == !(paddr_in inside {12'h000, 12'h004}))
        else $error("error flag wrong for address");
    AST_PRDATA_HOLD: assert property (!pready_out |-> $stable(prdata_out))
        else $error("read data moved between answers");
    AST_RAVAIL_EMPTY: assert property (s_rd_data ##0 !prdata_out[RVALID_BIT] |-> prdata_out[31:16] == 16'h0000)
        else $error("count left while nothing valid");
    AST_RAVAIL_MAX: assert property (s_rd_data |-> prdata_out[31:16] < RD_DEPTH)
        else $error("count left above incoming depth");
    AST_WSPACE_MAX: assert property (s_rd_ctrl |-> prdata_out[31:16] <= WR_DEPTH)
        else $error("space above outgoing depth");
    AST_IRQ_MASKED: assert property (s_rd_ctrl ##0 prdata_out[1:0] == 2'h0 |=> !irq_out [*2])
        else $error("interrupt with both masks off");
    AST_TX_HOLD: assert property (tx_valid_out && !(node_sel_in && tx_ready_in) |=> tx_valid_out && $stable(tx_data_out))
        else $error("outgoing byte changed before taken");
    AST_TX_FALL: assert property ($fell(tx_valid_out) |-> $past(node_sel_in) && $past(tx_ready_in))
        else $error("outgoing valid dropped untaken");
endmodule

bind jcu_top jcu_assertions #(.WR_DEPTH(WR_DEPTH), .RD_DEPTH(RD_DEPTH)) u_jcu_assertions (
    .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .irq_out(irq_out), .node_sel_in(node_sel_in), .tx_valid_out(tx_valid_out),
    .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in), .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in), .rx_ready_out(rx_ready_out));

// File: jcu_link_model.sv
// Purpose: hub and host side of the link, collects and sends bytes
// Assumes: same clock as the bridge
// Notes:   idle data line toggles so a stale byte is never mistaken
`timescale 1ns/10ps
module jcu_link_model (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    // bench controls
    input  wire logic       sel_in,
    input  wire logic       stall_in,
    // node side
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    input  wire logic       rx_ready_in,
    output logic            node_sel_out,
    output logic            tx_ready_out,
    output logic            rx_valid_out,
    output logic [7:0]      rx_data_out
);
    logic [7:0] got[$];
    logic [7:0] send[$];
    logic       take;
    assign take = rx_valid_out && node_sel_out && rx_ready_in;
    initial
    begin
        node_sel_out = 1'b0;
        tx_ready_out = 1'b0;
        rx_valid_out = 1'b0;
        rx_data_out  = 8'h00;
    end
    always @(posedge clk_in)
    begin
        if (srst_in)
        begin
            node_sel_out <= 1'b0;
            tx_ready_out <= 1'b0;
            rx_valid_out <= 1'b0;
        end
        else
        begin
            if (node_sel_out && tx_valid_in && tx_ready_out)
                got.push_back(tx_data_in);
            node_sel_out <= sel_in;
            tx_ready_out <= !stall_in;
            if (take || !rx_valid_out)
            begin
                if (send.size() > 0 && sel_in && !stall_in)
                begin
                    rx_valid_out <= 1'b1;
                    rx_data_out  <= send.pop_front();
                end
                else
                begin
                    rx_valid_out <= 1'b0;
                    rx_data_out  <= ~rx_data_out;
                end
            end
        end
    end
endmodule

// File: jcu_top_tb.sv
// Purpose: self-checking bench for the character bridge
// Assumes: depth 8 both ways, threshold 2, register style on one side
// Notes:   one mask write in flight at a time
`timescale 1ns/10ps
module jcu_top_tb;
    import jcu_pkg::*;
    localparam int unsigned DEPTH = 8;
    localparam logic [31:0] WSP   = 32'(DEPTH) << WSPACE_LSB;
    logic        clk_in = 1'b0, srst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
    logic        pwrite_in = 1'b0, sel = 1'b0, stall = 1'b0, err;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic        pready_out, pslverr_out, irq_out, node_sel_in, tx_valid_out;
    logic        tx_ready_in, rx_valid_in, rx_ready_out;
    logic [7:0]  tx_data_out, rx_data_in;
    int          fails = 0, checks = 0;
    always #4 clk_in = ~clk_in;
    jcu_top #(.WR_DEPTH(DEPTH), .RD_DEPTH(DEPTH), .WR_THRESH(2), .RD_THRESH(2),
        .WR_USE_REGS(1'b1), .RD_USE_REGS(1'b0)) u_jcu_top (
        .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
        .irq_out(irq_out), .node_sel_in(node_sel_in), .tx_valid_out(tx_valid_out),
        .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in), .rx_valid_in(rx_valid_in),
        .rx_data_in(rx_data_in), .rx_ready_out(rx_ready_out));
    jcu_link_model u_jcu_link_model (
        .clk_in(clk_in), .srst_in(srst_in), .sel_in(sel), .stall_in(stall),
        .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .rx_ready_in(rx_ready_out),
        .node_sel_out(node_sel_in), .tx_ready_out(tx_ready_in),
        .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, pready_out});
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic t_regs();
        apb(1'b0, 12'h004, 32'h0);
        chk("ctrl reset", WSP, rd);
        apb(1'b0, 12'h000, 32'h0);
        chk("data empty", 32'h0, rd);
        apb(1'b1, 12'h008, 32'h3);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped rd", 32'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_tx();
        int n;
        apb(1'b1, 12'h004, 32'h2);
        // fifo plus output stage hold depth+1 bytes; the last write is dropped
        for (int i = 0; i <= DEPTH + 1; i++)
            apb(1'b1, 12'h000, 32'ha0 + i);
        apb(1'b0, 12'h004, 32'h0);
        chk("wspace full", 32'h2, rd);
        chk("irq filling", 32'h0, {31'h0, irq_out});
        // link selected but stalled: nothing may leave
        sel <= 1'b1;
        stall <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk("tx stalled", 32'h0, u_jcu_link_model.got.size());
        stall <= 1'b0;
        for (n = 0; n < 100 && u_jcu_link_model.got.size() < DEPTH + 1; n++)
            @(posedge clk_in);
        repeat (3) @(posedge clk_in);
        chk("irq drained", 32'h1, {31'h0, irq_out});
        chk("tx count", DEPTH + 1, u_jcu_link_model.got.size());
        for (int i = 0; i < DEPTH + 1; i++)
            chk("tx byte", 32'ha0 + i, {24'h0, u_jcu_link_model.got[i]});
        apb(1'b0, 12'h004, 32'h0);
        chk("ctrl drained", WSP | 32'h602, rd);
        repeat (2) @(posedge clk_in);
        chk("irq cleared", 32'h0, {31'h0, irq_out});
        $display("test tx done");
    endtask
    task automatic t_rx();
        int n;
        apb(1'b1, 12'h004, 32'h400);
        for (int i = 0; i < DEPTH; i++)
            u_jcu_link_model.send.push_back(8'(8'h50 + i));
        for (n = 0; n < 100 && (u_jcu_link_model.send.size() > 0 || rx_valid_in); n++)
            @(posedge clk_in);
        repeat (3) @(posedge clk_in);
        chk("rx full", 32'h0, {31'h0, rx_ready_out});
        chk("irq masked", 32'h0, {31'h0, irq_out});
        apb(1'b0, 12'h004, 32'h0);
        chk("ctrl filled", WSP | 32'h500, rd);
        for (int i = 0; i < DEPTH; i++)
        begin
            apb(1'b0, 12'h000, 32'h0);
            chk("rx byte", {16'(DEPTH - 1 - i), 1'b1, 7'h00, 8'(8'h50 + i)}, rd);
        end
        apb(1'b0, 12'h000, 32'h0);
        chk("rx drained", 32'h0, rd);
        $display("test rx done");
    endtask
    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // single bus master only, so streams stay ordered
    initial
    begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        t_regs();
        t_tx();
        t_rx();
        results();
    end
    // tests take under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_in);
        fails++;
        results();
    end
endmodule
